//--- drive_seq_ctrl.v
// Run sequencer with keypad keys, jog, injection braking and APB registers
`include "drive_seq_regs.vh"
module drive_seq_ctrl #(
  parameter [23:0] TICK_CYCLES = `TICK_CYCLES
) (
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire [4:0]  term_seq_i,
  input  wire        key_run_i,
  input  wire        key_stop_i,
  input  wire        key_fwdrev_i,
  input  wire        zero_speed_i,
  output reg         run_o,
  output reg         jog_o,
  output reg         reverse_o,
  output reg         inject_o,
  output reg  [7:0]  boost_level_o,
  output reg         inhibit_o,
  output reg         running_o
);
  localparam [4:0] ST_READY   = 5'h01;
  localparam [4:0] ST_RUN     = 5'h02;
  localparam [4:0] ST_JOG     = 5'h04;
  localparam [4:0] ST_BRAKE   = 5'h08;
  localparam [4:0] ST_INHIBIT = 5'h10;

  reg  [2:0]  seq_mode;
  reg  [2:0]  ref_sel;
  reg  [1:0]  stop_mode;
  reg         key_en_run;
  reg         key_en_stop;
  reg         key_en_fr;
  reg         out_en;
  reg  [4:0]  cmd_bits;
  reg  [7:0]  jog_min;
  reg  [7:0]  inj_level;
  reg  [7:0]  inj_time;
  reg  [23:0] tick_cnt;
  reg         tick;
  reg         key_run_d;
  reg         key_stop_d;
  reg         key_fr_d;
  reg         run_latch;
  reg         rev_latch;
  reg  [4:0]  state;
  reg  [4:0]  next_state;
  reg         go;
  reg         jog_sel;
  reg         rev_cmd;
  reg         jog_load;
  reg         brake_load;
  reg  [31:0] next_rdata;
  reg         next_err;

  wire [4:0]  seq;
  wire        enable;
  wire        keypad;
  wire        bits_latch;
  wire        need_en;
  wire        held;
  wire        run_key;
  wire        stop_key;
  wire        fr_key;
  wire        go_ok;
  wire        run_cmd;
  wire        jog_cmd;
  wire        blocked;
  wire        jog_min_ok;
  wire        jog_busy;
  wire        brake_busy;
  wire        apb_setup;
  wire        apb_write;
  wire        to_brake;
  wire [5:0]  log_min;
  wire [4:0]  log_hr;
  wire [8:0]  log_day;
  wire [7:0]  log_yr;

  // Limit a written parameter to its top value
  function [7:0] clamp_param;
    input [31:0] v;
    begin
      if (v > {24'h000000, `PARAM_MAX}) begin
        clamp_param = `PARAM_MAX;
      end else begin
        clamp_param = v[7:0];
      end
    end
  endfunction

  // Command bits are the terminals merged with the serial writes
  assign seq        = cmd_bits | term_seq_i;
  assign enable     = seq[`CMD_ENABLE];
  assign keypad     = (ref_sel == `REF_KEYPAD);
  assign bits_latch = !keypad && (seq_mode <= `SEQ_LATCH_MAX);
  assign need_en    = keypad || (seq_mode <= `SEQ_WIRE_PROOF);
  assign held       = bits_latch && (seq[3:0] != 4'h0);
  assign jog_min_ok = keypad || (seq_mode <= `SEQ_LATCH_MAX);

  // Keys act on their rising edge when keypad reference is chosen, or when enabled in a latching mode
  assign run_key  = key_run_i && !key_run_d && (key_en_run || keypad) &&
                    (keypad || bits_latch);
  assign stop_key = key_stop_i && !key_stop_d && (key_en_stop || keypad) &&
                    (keypad || bits_latch);
  assign fr_key   = key_fwdrev_i && !key_fr_d && (key_en_fr || keypad) &&
                    (keypad || bits_latch);

  // Without output enable, or drive enable where needed, nothing runs
  assign blocked = !out_en || (need_en && !enable);
  assign go_ok   = go && !blocked;
  assign run_cmd = go_ok && !jog_sel;
  assign jog_cmd = go_ok && jog_sel;
  assign to_brake = (stop_mode == `STOP_INJ) || (stop_mode == `STOP_TIMED);

  assign apb_setup = psel_i && penable_i && !pready_o;
  assign apb_write = psel_i && penable_i && pready_o && pwrite_i;

  // Tenth of a second tick
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt <= 24'h000000;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES - 24'h000001) begin
      tick_cnt <= 24'h000000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 24'h000001;
      tick     <= 1'b0;
    end
  end

  // Key history for edge detection
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      key_run_d  <= 1'b0;
      key_stop_d <= 1'b0;
      key_fr_d   <= 1'b0;
    end else begin
      key_run_d  <= key_run_i;
      key_stop_d <= key_stop_i;
      key_fr_d   <= key_fwdrev_i;
    end
  end

  // Latched run and direction for keypad and latching modes
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      run_latch <= 1'b0;
      rev_latch <= 1'b0;
    end else begin
      if (blocked || (stop_key && !held)) begin
        run_latch <= 1'b0;
      end else if (run_key || (bits_latch && (seq[0] || seq[2]))) begin
        run_latch <= 1'b1;
      end
      if (bits_latch && seq[0]) begin
        rev_latch <= 1'b0;
      end else if (bits_latch && seq[2]) begin
        rev_latch <= 1'b1;
      end else if (fr_key && !held) begin
        rev_latch <= !rev_latch;
      end
    end
  end

  // Command decode per sequencing mode
  always @* begin
    go      = 1'b0;
    jog_sel = 1'b0;
    rev_cmd = 1'b0;
    if (keypad) begin
      go      = run_latch;
      rev_cmd = rev_latch;
    end else if (bits_latch) begin
      go      = run_latch || seq[1] || seq[3];
      jog_sel = !run_latch;
      rev_cmd = run_latch ? rev_latch : seq[3];
    end else if (seq_mode == `SEQ_PLC) begin
      go      = seq[0];
      jog_sel = seq[1];
      rev_cmd = seq[2];
    end else begin
      go      = seq[0] ^ seq[2];
      jog_sel = seq[1];
      rev_cmd = seq[2];
    end
  end

  // Sequencer state transitions
  always @* begin
    next_state = state;
    jog_load   = 1'b0;
    brake_load = 1'b0;
    case (state)
      ST_READY: begin
        if (run_cmd) begin
          next_state = ST_RUN;
        end else if (jog_cmd) begin
          next_state = ST_JOG;
          jog_load   = 1'b1;
        end
      end
      ST_RUN: begin
        if (!go_ok) begin
          next_state = to_brake ? ST_BRAKE : ST_READY;
          brake_load = to_brake;
        end
      end
      ST_JOG: begin
        if (run_cmd) begin
          next_state = ST_RUN;
        end else if (!jog_cmd && !jog_busy) begin
          next_state = to_brake ? ST_BRAKE : ST_READY;
          brake_load = to_brake;
        end
      end
      ST_BRAKE: begin
        if (run_cmd) begin
          next_state = ST_RUN;
        end else if (stop_mode == `STOP_TIMED) begin
          if (!brake_busy) begin
            next_state = ST_READY;
          end
        end else if (zero_speed_i || !to_brake) begin
          next_state = ST_READY;
        end
      end
      ST_INHIBIT: begin
        if (!blocked) begin
          next_state = ST_READY;
        end
      end
      default: begin
        next_state = ST_READY;
      end
    endcase
    if (blocked) begin
      next_state = ST_INHIBIT;
      jog_load   = 1'b0;
      brake_load = 1'b0;
    end
  end

  // State register
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_READY;
    end else begin
      state <= next_state;
    end
  end

  // Minimum jog period, zero where the mode ignores it
  tenths_timer jog_timer (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .tick_i  (tick),
    .load_i  (jog_load),
    .value_i (jog_min_ok ? jog_min : 8'h00),
    .busy_o  (jog_busy)
  );

  // Injection braking time for the timed stop mode
  tenths_timer brake_timer (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .tick_i  (tick),
    .load_i  (brake_load),
    .value_i ((stop_mode == `STOP_TIMED) ? inj_time : 8'h00),
    .busy_o  (brake_busy)
  );

  // Accumulated running time
  run_time_log run_log (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .tick_i    (tick),
    .running_i (running_o),
    .minutes_o (log_min),
    .hours_o   (log_hr),
    .days_o    (log_day),
    .years_o   (log_yr)
  );

  // Drive outputs registered from the next state, changing with the state register
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      run_o         <= 1'b0;
      jog_o         <= 1'b0;
      reverse_o     <= 1'b0;
      inject_o      <= 1'b0;
      boost_level_o <= 8'h00;
      inhibit_o     <= 1'b0;
      running_o     <= 1'b0;
    end else begin
      run_o     <= (next_state == ST_RUN);
      jog_o     <= (next_state == ST_JOG);
      running_o <= (next_state == ST_RUN) || (next_state == ST_JOG);
      inhibit_o <= (next_state == ST_INHIBIT);
      inject_o  <= (next_state == ST_BRAKE);
      if ((next_state == ST_RUN) || (next_state == ST_JOG)) begin
        reverse_o <= rev_cmd;
      end
      boost_level_o <= (next_state == ST_BRAKE) ? inj_level : 8'h00;
    end
  end

  // Register writes at the access edge
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      seq_mode    <= 3'h0;
      ref_sel     <= 3'h0;
      stop_mode   <= 2'h0;
      key_en_run  <= 1'b0;
      key_en_stop <= 1'b0;
      key_en_fr   <= 1'b0;
      out_en      <= 1'b1;
      cmd_bits    <= `CMD_RESET;
      jog_min     <= `JOG_MIN_RESET;
      inj_level   <= `INJ_LEVEL_RESET;
      inj_time    <= `INJ_TIME_RESET;
    end else if (apb_write) begin
      case (paddr_i)
        `OFS_CTRL: begin
          seq_mode    <= pwdata_i[`CTRL_SEQ_LSB +: 3];
          ref_sel     <= pwdata_i[`CTRL_REF_LSB +: 3];
          stop_mode   <= pwdata_i[`CTRL_STOP_LSB +: 2];
          key_en_run  <= pwdata_i[`CTRL_KEY_RUN];
          key_en_stop <= pwdata_i[`CTRL_KEY_STOP];
          key_en_fr   <= pwdata_i[`CTRL_KEY_FR];
          out_en      <= pwdata_i[`CTRL_OUT_EN];
        end
        `OFS_CMD: begin
          cmd_bits <= pwdata_i[4:0];
        end
        `OFS_JOG_MIN: begin
          jog_min <= clamp_param(pwdata_i);
        end
        `OFS_INJ_LEVEL: begin
          inj_level <= clamp_param(pwdata_i);
        end
        `OFS_INJ_TIME: begin
          inj_time <= clamp_param(pwdata_i);
        end
        default: begin
          cmd_bits <= cmd_bits;
        end
      endcase
    end
  end

  // Read multiplexer and address decode
  always @* begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    case (paddr_i)
      `OFS_CTRL: begin
        next_rdata[`CTRL_SEQ_LSB +: 3]  = seq_mode;
        next_rdata[`CTRL_REF_LSB +: 3]  = ref_sel;
        next_rdata[`CTRL_STOP_LSB +: 2] = stop_mode;
        next_rdata[`CTRL_KEY_RUN]       = key_en_run;
        next_rdata[`CTRL_KEY_STOP]      = key_en_stop;
        next_rdata[`CTRL_KEY_FR]        = key_en_fr;
        next_rdata[`CTRL_OUT_EN]        = out_en;
      end
      `OFS_CMD:       next_rdata[4:0] = cmd_bits;
      `OFS_JOG_MIN:   next_rdata[7:0] = jog_min;
      `OFS_INJ_LEVEL: next_rdata[7:0] = inj_level;
      `OFS_INJ_TIME:  next_rdata[7:0] = inj_time;
      `OFS_STATUS: begin
        next_rdata[4:0] = {inhibit_o, inject_o, jog_o, reverse_o, running_o};
        next_rdata[12:8] = seq; // Merged command bits
      end
      `OFS_RUNLOG_LO: begin
        next_rdata[5:0] = log_min;
        next_rdata[`LOG_HR_LSB +: 5] = log_hr;
      end
      `OFS_RUNLOG_HI: begin
        next_rdata[8:0] = log_day;
        next_rdata[`LOG_YR_LSB +: 8] = log_yr;
      end
      default: next_err = 1'b1;
    endcase
  end

  // APB answer one cycle into the access phase
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else if (apb_setup) begin
      pready_o  <= 1'b1;
      prdata_o  <= pwrite_i ? 32'h00000000 : next_rdata;
      pslverr_o <= next_err;
    end else begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end
  end
endmodule

//--- drive_seq_regs.vh
// Register map, field positions, reset values and timing of the run sequencer
`ifndef DRIVE_SEQ_REGS_VH
`define DRIVE_SEQ_REGS_VH
// Byte offsets on the APB bus
`define OFS_CTRL        12'h000
`define OFS_CMD         12'h004
`define OFS_JOG_MIN     12'h008
`define OFS_INJ_LEVEL   12'h00c
`define OFS_INJ_TIME    12'h010
`define OFS_STATUS      12'h014
`define OFS_RUNLOG_LO   12'h018
`define OFS_RUNLOG_HI   12'h01c
// Control word fields
`define CTRL_SEQ_LSB    0
`define CTRL_REF_LSB    4
`define CTRL_STOP_LSB   8
`define CTRL_KEY_RUN    12
`define CTRL_KEY_STOP   13
`define CTRL_KEY_FR     14
`define CTRL_OUT_EN     16
// Command bits: four sequencing bits and drive enable
`define CMD_ENABLE      4
`define CMD_RESET       5'h00
// Parameter resets, tenths of a second or tenths of a percent
`define JOG_MIN_RESET   8'h00
`define INJ_LEVEL_RESET 8'h64
`define INJ_TIME_RESET  8'h32
`define PARAM_MAX       8'hfa
// Mode codes
`define REF_KEYPAD      3'h4
`define SEQ_LATCH_MAX   3'h1
`define SEQ_WIRE_PROOF  3'h2
`define SEQ_PLC         3'h3
`define STOP_INJ        2'h2
`define STOP_TIMED      2'h3
// Run time log limits
`define LOG_MIN_MAX     6'h3b
`define LOG_HR_MAX      5'h17
`define LOG_DAY_MAX     9'h16c
`define LOG_YR_MAX      8'hfa
`define LOG_HR_LSB      8
`define LOG_YR_LSB      16
// Timing: clocks per tenth of a second at 10 ns, tenths per minute
`define TICK_CYCLES     24'h989680
`define TICKS_PER_MIN   10'h258
`endif

//--- tenths_timer.v
// Countdown timer in tenths of a second, never shorter than its load value
module tenths_timer (
  input  wire       clk_i,
  input  wire       reset_i,
  input  wire       tick_i,
  input  wire       load_i,
  input  wire [7:0] value_i,
  output wire       busy_o
);
  reg  [8:0] count;
  wire [8:0] start;

  // One extra tick covers the partial first tenth
  assign start = {1'b0, value_i} + {8'h00, (value_i != 8'h00)};
  assign busy_o = (count != 9'h000);

  // Load or count down on each tick
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count <= 9'h000;
    end else if (load_i) begin
      count <= start;
    end else if (tick_i && busy_o) begin
      count <= count - 9'h001;
    end
  end
endmodule

//--- run_time_log.v
// Run time log in whole minutes, hours, days and years
`include "drive_seq_regs.vh"
module run_time_log (
  input  wire       clk_i,
  input  wire       reset_i,
  input  wire       tick_i,
  input  wire       running_i,
  output reg  [5:0] minutes_o,
  output reg  [4:0] hours_o,
  output reg  [8:0] days_o,
  output reg  [7:0] years_o
);
  reg  [9:0] part;
  wire       full;
  wire       minute_done;

  assign full = (years_o == `LOG_YR_MAX) && (days_o == `LOG_DAY_MAX) &&
                (hours_o == `LOG_HR_MAX) && (minutes_o == `LOG_MIN_MAX);
  assign minute_done = tick_i && running_i && (part == `TICKS_PER_MIN - 10'h001);

  // Partial minute, lost at reset and never logged
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      part <= 10'h000;
    end else if (minute_done) begin
      part <= 10'h000;
    end else if (tick_i && running_i) begin
      part <= part + 10'h001;
    end
  end

  // Whole minutes carry into larger units, holding at the top
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      minutes_o <= 6'h00;
      hours_o   <= 5'h00;
      days_o    <= 9'h000;
      years_o   <= 8'h00;
    end else if (minute_done && !full) begin
      if (minutes_o != `LOG_MIN_MAX) begin
        minutes_o <= minutes_o + 6'h01;
      end else begin
        minutes_o <= 6'h00;
        if (hours_o != `LOG_HR_MAX) begin
          hours_o <= hours_o + 5'h01;
        end else begin
          hours_o <= 5'h00;
          if (days_o != `LOG_DAY_MAX) begin
            days_o <= days_o + 9'h001;
          end else begin
            days_o  <= 9'h000;
            years_o <= years_o + 8'h01;
          end
        end
      end
    end
  end
endmodule

//--- drive_seq_ctrl_assertions.sv
// Concurrent checks on the run sequencer ports
module drive_seq_ctrl_checker #(
  parameter [23:0] TICK_CYCLES = 24'h000001
) (
  input wire        clk_i,
  input wire        reset_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire [4:0]  term_seq_i,
  input wire        key_run_i,
  input wire        key_stop_i,
  input wire        key_fwdrev_i,
  input wire        zero_speed_i,
  input wire        run_o,
  input wire        jog_o,
  input wire        reverse_o,
  input wire        inject_o,
  input wire [7:0]  boost_level_o,
  input wire        inhibit_o,
  input wire        running_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Bus transfer steps
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  // Bus answer timing
  a_ready_one_wait: assert property (s_setup ##1 s_access |=> pready_o)
    else $error("ready not one cycle after access");
  a_ready_single: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  // Run state relations
  a_running_merge: assert property (running_o == (run_o || jog_o))
    else $error("running indicator wrong");
  a_inhibit_no_run: assert property (inhibit_o |-> !running_o)
    else $error("running while inhibited");
  a_brake_not_run: assert property (inject_o |-> !running_o)
    else $error("braking while running");
  a_boost_idle_zero: assert property (!inject_o |-> boost_level_o == 8'h00)
    else $error("boost outside braking");
  a_boost_cap: assert property (inject_o |-> boost_level_o <= 8'hfa)
    else $error("boost above limit");
  a_brake_after_run: assert property ($rose(inject_o) |-> $past(running_o))
    else $error("braking not from run");
  a_reset_idle: assert property ($past(reset_i) |-> !running_o && !inject_o)
    else $error("active right after reset");
endmodule

bind drive_seq_ctrl drive_seq_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk_i         (clk_i),
  .reset_i       (reset_i),
  .psel_i        (psel_i),
  .penable_i     (penable_i),
  .pwrite_i      (pwrite_i),
  .paddr_i       (paddr_i),
  .pwdata_i      (pwdata_i),
  .prdata_o      (prdata_o),
  .pready_o      (pready_o),
  .pslverr_o     (pslverr_o),
  .term_seq_i    (term_seq_i),
  .key_run_i     (key_run_i),
  .key_stop_i    (key_stop_i),
  .key_fwdrev_i  (key_fwdrev_i),
  .zero_speed_i  (zero_speed_i),
  .run_o         (run_o),
  .jog_o         (jog_o),
  .reverse_o     (reverse_o),
  .inject_o      (inject_o),
  .boost_level_o (boost_level_o),
  .inhibit_o     (inhibit_o),
  .running_o     (running_o)
);

//--- drive_io_model.sv
// Terminal, keypad and speed feedback stand-in for the sequencer
module drive_io_model (
  input  wire        clk_i,
  output logic [4:0] term_seq_o,
  output logic [2:0] keys_o,
  output logic       zero_speed_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Terminals open and keys released at power-up
  initial begin
    term_seq_o = 5'h00;
    keys_o = 3'h0;
    zero_speed_o = 1'b0;
  end
  // Five command bits driven as levels
  task automatic set_bits(input logic [4:0] b);
    @(posedge clk_i);
    term_seq_o <= b;
  endtask
  // Press one key for three cycles, then let it settle
  task automatic press(input int k);
    @(posedge clk_i);
    keys_o[k] <= 1'b1;
    repeat (3) @(posedge clk_i);
    keys_o[k] <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic set_zero(input logic v);
    @(posedge clk_i);
    zero_speed_o <= v;
  endtask
endmodule

//--- drive_seq_ctrl_tb.sv
// Self-checking bench for the run sequencer
`include "drive_seq_regs.vh"
module drive_seq_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, run_o, jog_o, reverse_o, inject_o, inhibit_o, running_o;
  wire  [7:0]  boost_level_o;
  wire  [4:0]  term_seq;
  wire  [2:0]  keys;
  wire         zero_speed;
  int          err_count = 0;
  int          checked = 0;
  int          cycles = 0;

  drive_io_model io (
    .clk_i        (clk_i),
    .term_seq_o   (term_seq),
    .keys_o       (keys),
    .zero_speed_o (zero_speed)
  );
  drive_seq_ctrl #(.TICK_CYCLES(24'h000001)) dut (
    .clk_i         (clk_i),
    .reset_i       (reset_i),
    .psel_i        (psel_i),
    .penable_i     (penable_i),
    .pwrite_i      (pwrite_i),
    .paddr_i       (paddr_i),
    .pwdata_i      (pwdata_i),
    .prdata_o      (prdata_o),
    .pready_o      (pready_o),
    .pslverr_o     (pslverr_o),
    .term_seq_i    (term_seq),
    .key_run_i     (keys[0]),
    .key_stop_i    (keys[1]),
    .key_fwdrev_i  (keys[2]),
    .zero_speed_i  (zero_speed),
    .run_o         (run_o),
    .jog_o         (jog_o),
    .reverse_o     (reverse_o),
    .inject_o      (inject_o),
    .boost_level_o (boost_level_o),
    .inhibit_o     (inhibit_o),
    .running_o     (running_o)
  );

  // Clock and hang guard
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 45000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude;
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic do_reset;
    reset_i <= 1'b1;
    cyc(10);
    reset_i <= 1'b0;
  endtask
  // One bus transfer, held until ready is sampled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string name);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h00000000, rd, err);
    check(name, rd, exp);
  endtask
  // Control word from its fields
  function automatic logic [31:0] cw(input logic [2:0] seq, rsel, input logic [1:0] stp,
                                     input logic [2:0] ken, input logic oe);
    return {15'h0000, oe, 1'b0, ken, 2'b00, stp, 1'b0, rsel, 1'b0, seq};
  endfunction

  task automatic t_reset;
    logic [31:0] rd;
    logic        err;
    cyc(2);
    check("inhibit", inhibit_o, 32'h1);
    rdchk(`OFS_CTRL, 32'h00010000, "ctrl");
    rdchk(`OFS_CMD, 32'h0, "cmd");
    rdchk(`OFS_JOG_MIN, 32'h0, "jog_min");
    rdchk(`OFS_INJ_LEVEL, 32'h64, "inj_level");
    rdchk(`OFS_INJ_TIME, 32'h32, "inj_time");
    rdchk(`OFS_STATUS, 32'h10, "status");
    wr(`OFS_JOG_MIN, 32'hff);
    rdchk(`OFS_JOG_MIN, 32'hfa, "jog_clamp");
    wr(`OFS_RUNLOG_LO, 32'h3f);
    rdchk(`OFS_RUNLOG_LO, 32'h0, "log_ro");
    apb(1'b0, 12'h020, 32'h0, rd, err);
    check("slverr", err, 32'h1);
    check("unmapped", rd, 32'h0);
  endtask
  task automatic t_keypad;
    wr(`OFS_CTRL, cw(3'h0, 3'h4, 2'h0, 3'h0, 1'b1));
    io.press(0);
    check("kp_no_enable", run_o, 32'h0);
    wr(`OFS_CMD, 32'h1f);
    cyc(3);
    check("kp_seq_bits", run_o, 32'h0);
    wr(`OFS_CMD, 32'h10);
    io.press(0);
    check("kp_run", run_o, 32'h1);
    io.press(2);
    check("kp_reverse", reverse_o, 32'h1);
    io.press(1);
    check("kp_stop", run_o, 32'h0);
  endtask
  task automatic t_keyen;
    wr(`OFS_CTRL, cw(3'h1, 3'h0, 2'h0, 3'h0, 1'b1));
    io.press(0);
    check("run_key_off", run_o, 32'h0);
    wr(`OFS_CTRL, cw(3'h1, 3'h0, 2'h0, 3'h1, 1'b1));
    io.press(0);
    check("run_key_on", run_o, 32'h1);
    io.press(1);
    check("stop_key_off", run_o, 32'h1);
    wr(`OFS_CTRL, cw(3'h1, 3'h0, 2'h0, 3'h3, 1'b1));
    io.press(1);
    check("stop_key_on", run_o, 32'h0);
    io.press(0);
    wr(`OFS_CTRL, cw(3'h1, 3'h0, 2'h0, 3'h3, 1'b0));
    cyc(2);
    check("oe_off_run", run_o, 32'h0);
    check("oe_off_inh", inhibit_o, 32'h1);
    io.press(0);
    check("oe_off_key", run_o, 32'h0);
    wr(`OFS_CTRL, cw(3'h1, 3'h0, 2'h0, 3'h0, 1'b1));
    cyc(2);
    check("oe_on_inh", inhibit_o, 32'h0);
  endtask
  task automatic t_jog;
    wr(`OFS_JOG_MIN, 32'h14);
    io.set_bits(5'h12);
    io.set_bits(5'h10);
    cyc(8);
    check("jog_held", jog_o, 32'h1);
    cyc(25);
    check("jog_ended", jog_o, 32'h0);
    wr(`OFS_CTRL, cw(3'h2, 3'h0, 2'h0, 3'h0, 1'b1));
    io.set_bits(5'h12);
    io.set_bits(5'h13);
    cyc(3);
    check("wp_jog", jog_o, 32'h1);
    io.set_bits(5'h10);
    cyc(3);
    check("wp_jog_off", jog_o, 32'h0);
    wr(`OFS_CMD, 32'h0);
  endtask
  task automatic t_brake;
    io.set_bits(5'h00);
    wr(`OFS_CTRL, cw(3'h3, 3'h0, 2'h3, 3'h0, 1'b1));
    wr(`OFS_INJ_LEVEL, 32'h20);
    wr(`OFS_INJ_TIME, 32'h1e);
    io.set_bits(5'h01);
    cyc(3);
    check("plc_run", run_o, 32'h1);
    check("plc_running", running_o, 32'h1);
    io.set_bits(5'h00);
    cyc(2);
    check("brake_on", inject_o, 32'h1);
    check("boost", boost_level_o, 32'h20);
    cyc(20);
    check("brake_hold", inject_o, 32'h1);
    cyc(15);
    check("brake_end", inject_o, 32'h0);
    check("boost_off", boost_level_o, 32'h0);
    wr(`OFS_CTRL, cw(3'h3, 3'h0, 2'h2, 3'h0, 1'b1));
    io.set_bits(5'h01);
    cyc(3);
    io.set_bits(5'h00);
    cyc(40);
    check("zs_brake", inject_o, 32'h1);
    io.set_zero(1'b1);
    cyc(3);
    check("zs_end", inject_o, 32'h0);
    io.set_zero(1'b0);
  endtask
  task automatic t_log;
    io.set_bits(5'h01);
    cyc(500);
    wr(`OFS_CMD, 32'h0f);
    do_reset;
    rdchk(`OFS_CMD, 32'h0, "cmd_cleared");
    wr(`OFS_CTRL, cw(3'h3, 3'h0, 2'h0, 3'h0, 1'b1));
    cyc(500);
    rdchk(`OFS_RUNLOG_LO, 32'h0, "log_partial");
    cyc(35800);
    io.set_bits(5'h00);
    cyc(3);
    rdchk(`OFS_RUNLOG_LO, 32'h100, "log_hour");
    rdchk(`OFS_RUNLOG_HI, 32'h0, "log_days");
  endtask

  // Main sequence
  initial begin
    do_reset;
    t_reset;
    t_keypad;
    t_keyen;
    t_jog;
    t_brake;
    t_log;
    conclude;
  end
endmodule
